/* dv/testbench.sv */
// self-checking bench: register tasks over avalon-mm, far-end uart model
// assumes a waitrequest-paced avalon-mm slave
`include "uart_brg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_in;
    logic        rst_n_in = 1'b0;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    wire  [31:0] avs_readdata_out;
    wire         avs_waitrequest_out;
    wire         rx_line;
    wire         tx_line_out;
    wire         irq_out;
    logic [31:0] rd_q;
    int          err_total = 0;
    int          checks_done = 0;
    int          n;
    uart_baud_gen_rx_fifo dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .rx_line_in(rx_line), .tx_line_out(tx_line_out), .irq_out(irq_out));
    uart_far_end far_u (.clk_in(clk_in), .tx_line_in(tx_line_out), .rx_line_out(rx_line), .got_byte_out());
    // 40 mhz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////
    // one bus access; the request is held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int c;
        c = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
            c++;
        end while (avs_waitrequest_out !== 1'b0 && c < 100);
        rd_q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (c >= 100) err_total++;
        @(posedge clk_in);
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        chk_word(nm, e, rd_q & m);
    endtask
    function automatic logic [7:0] pat(input int t, input int k);
        return 8'(8'h96 ^ (t * 17 + k * 41));
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog: tests need well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk_in);
        err_total++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd_chk("fcr reset", `OFS_FIFO_CTRL, 32'h0, '1);
        rd_chk("count reset", `OFS_RX_COUNT, 32'h0, '1);
        rd_chk("empty data", `OFS_DATA, 32'h0, '1);
        rd_chk("unmapped", 8'hFC, 32'h0, '1);
        xfer(1'b1, `OFS_DIV_LO, 32'h10);
        xfer(1'b1, `OFS_DIV_HI, 32'h00);
        xfer(1'b1, `OFS_FIFO_CTRL, 32'hFF);
        rd_chk("fcr upper", `OFS_FIFO_CTRL, 32'h3F, '1);
        xfer(1'b1, `OFS_CHAN_CTRL, 32'h03);
        xfer(1'b1, `OFS_RX_COUNT, 32'h07);
        rd_chk("count ro", `OFS_RX_COUNT, 32'h0, '1);
        $display("test registers done");
        // each trigger code; one glitched sample per bit is outvoted
        far_u.frac_q = 3;
        far_u.glo_q = 11;
        far_u.ghi_q = 12;
        for (int t = 0; t < 4; t++) begin
            xfer(1'b1, `OFS_FIFO_CTRL, 32'(24 + t));
            for (int k = 1; k <= 4; k++) begin
                far_u.send_byte(pat(t, k));
                rd_chk("count", `OFS_RX_COUNT, 32'(k), '1);
                rd_chk("rx flag", `OFS_LINE_STATUS, 32'((t == 0) ? (k == 4) : (k >= t)), 32'h1);
                chk_bit("irq level", (t == 0) ? (k == 4) : (k >= t), irq_out);
            end
            for (int k = 1; k <= 4 && t < 3; k++) rd_chk("pop", `OFS_DATA, 32'(pat(t, k)), '1);
        end
        $display("test trigger done");
        // fifth and sixth byte with a full fifo; only overrun unmasked
        xfer(1'b1, `OFS_CHAN_CTRL, 32'h01);
        xfer(1'b1, `OFS_IRQ_MASK, 32'h02);
        far_u.send_byte(8'hE7);
        far_u.send_byte(8'h7E);
        rd_chk("count full", `OFS_RX_COUNT, 32'h4, '1);
        rd_chk("hold flag", `OFS_LINE_STATUS, 32'h4, 32'h4);
        chk_bit("irq overrun", 1'b1, irq_out);
        rd_chk("overrun", `OFS_IRQ_STATUS, 32'h2, 32'h2);
        @(posedge clk_in);
        chk_bit("irq cleared", 1'b0, irq_out);
        for (int k = 1; k <= 4; k++) begin
            rd_chk("pop full", `OFS_DATA, 32'(pat(3, k)), '1);
            if (k == 1) rd_chk("count held", `OFS_RX_COUNT, 32'h4, '1);
        end
        rd_chk("held byte", `OFS_DATA, 32'h7E, '1);
        rd_chk("count drained", `OFS_RX_COUNT, 32'h0, '1);
        $display("test overrun done");
        // divisor 8, range 1, fraction 7; glitch hits one sample
        xfer(1'b1, `OFS_DIV_LO, 32'h08);
        xfer(1'b1, `OFS_DIV_HI, 32'h00);
        xfer(1'b1, `OFS_FIFO_CTRL, 32'h3D);
        far_u.div_q = 8;
        far_u.frac_q = 7;
        far_u.glo_q = 5;
        far_u.ghi_q = 6;
        far_u.send_byte(8'hC6);
        far_u.send_byte(8'h39);
        rd_chk("range1 a", `OFS_DATA, 32'hC6, '1);
        rd_chk("range1 b", `OFS_DATA, 32'h39, '1);
        $display("test sampling done");
        // transmit with tx-done unmasked
        xfer(1'b1, `OFS_IRQ_MASK, 32'h08);
        xfer(1'b1, `OFS_DATA, 32'hC3);
        for (n = 0; n < 400 && irq_out !== 1'b1; n++) @(posedge clk_in);
        chk_bit("irq tx", 1'b1, irq_out);
        chk_word("tx byte", 32'hC3, 32'(far_u.got_byte_out));
        rd_chk("tx status", `OFS_IRQ_STATUS, 32'h8, 32'h8);
        @(posedge clk_in);
        chk_bit("irq tx clear", 1'b0, irq_out);
        $display("test transmit done");
        // channel off and on flushes the count
        far_u.send_byte(8'h5A);
        rd_chk("count one", `OFS_RX_COUNT, 32'h1, '1);
        xfer(1'b1, `OFS_CHAN_CTRL, 32'h00);
        xfer(1'b1, `OFS_CHAN_CTRL, 32'h01);
        rd_chk("count flushed", `OFS_RX_COUNT, 32'h0, '1);
        $display("test enable done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

/* dv/uart_brg_chk.sv */
// port-level checker for the uart baud generator and receive fifo
// assumes one clock domain and the one-wait-cycle bus answer
`include "uart_brg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module uart_brg_chk (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    // register bus
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    // line and interrupt
    input wire logic        tx_line_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // read answer cycle, address still held by the master
    wire logic rd_ack_w = avs_read_in && !avs_waitrequest_out;
    ////////////////////////////////////////////////////////////////
    wait_one_a:
        assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer late");
    wait_pulse_a:
        assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("wait low too long");
    wait_cause_a:
        assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
        else $error("answer without request");
    read_stand_a:
        assert property (!avs_read_in && !avs_write_in |=> $stable(avs_readdata_out)) else $error("read data moved");
    reset_quiet_a:
        assert property (@(posedge clk_in) disable iff (1'b0)
            !rst_n_in |=> avs_waitrequest_out && !irq_out && tx_line_out) else $error("outputs busy in reset");
    count_upper_a:
        assert property (rd_ack_w && avs_address_in == `OFS_RX_COUNT |-> avs_readdata_out[31:3] == 29'h0)
        else $error("count upper bits set");
    count_max_a:
        assert property (rd_ack_w && avs_address_in == `OFS_RX_COUNT |-> avs_readdata_out[2:0] <= 3'h4)
        else $error("count above four");
    fcr_upper_a:
        assert property (rd_ack_w && avs_address_in == `OFS_FIFO_CTRL |-> avs_readdata_out[31:6] == 26'h0)
        else $error("control upper bits set");
    start_min_a:
        assert property ($fell(tx_line_out) |=> !tx_line_out [*7]) else $error("start bit too short");
    // main scenarios
    full_c: cover property (rd_ack_w && avs_address_in == `OFS_RX_COUNT && avs_readdata_out[2:0] == 3'h4);
    irq_c: cover property ($rose(irq_out));
    tx_c: cover property ($fell(tx_line_out));
endmodule // uart_brg_chk
bind uart_baud_gen_rx_fifo uart_brg_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .tx_line_out(tx_line_out), .irq_out(irq_out));
`default_nettype wire

/* dv/uart_far_end.sv */
// far-end uart model: drives the receive line, captures the transmit line
// assumes the bench sets bit time, fraction and glitch window per scenario
`timescale 1ns/1ps
`default_nettype none
module uart_far_end (
    // clock and lines
    input  wire logic       clk_in,
    input  wire logic       tx_line_in,
    output var  logic       rx_line_out,
    // last byte seen from the device
    output var  logic [7:0] got_byte_out
);
    int div_q = 16;
    int frac_q = 0;
    int glo_q = 99;
    int ghi_q = 99;
    initial rx_line_out = 1'b1;
    initial got_byte_out = 8'h00;
    ////////////////////////////////////////////////////////////////
    // carry out of the low three bits stretches that bit by one clock
    function automatic int bit_len(inout int acc);
        acc = acc + frac_q;
        bit_len = div_q + (acc >> 3);
        acc = acc & 7;
    endfunction
    ////////////////////////////////////////////////////////////////
    // one 8n1 frame, lsb first; glitch in data bits only
    task automatic send_byte(input logic [7:0] b);
        int acc;
        int n;
        acc = 0;
        for (int k = 0; k < 10; k++) begin
            n = bit_len(acc);
            for (int c = 0; c < n; c++) begin
                @(posedge clk_in);
                rx_line_out <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1] ^ logic'(c >= glo_q && c <= ghi_q);
            end
        end
        repeat (4) @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////
    // capture a device frame, sampling each bit near its middle
    initial begin : capture
        int acc;
        int n;
        logic [7:0] b;
        forever begin
            @(negedge tx_line_in);
            acc = 0;
            n = bit_len(acc);
            repeat (n) @(posedge clk_in);
            for (int k = 0; k < 8; k++) begin
                n = bit_len(acc);
                repeat (n / 2) @(posedge clk_in);
                b[k] = tx_line_in;
                repeat (n - n / 2) @(posedge clk_in);
            end
            got_byte_out <= b;
        end
    end
endmodule // uart_far_end
`default_nettype wire

/* rtl/bit_timer.v */
// bit-time counter with fractional modulation and three sample strobes
// assumes divisor and fraction are held steady during a frame
`timescale 1ns/1ps
`default_nettype none

module bit_timer (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // control
    input  wire        restart_in,
    input  wire [15:0] divisor_in,
    input  wire [2:0]  fraction_in,
    input  wire        range_sel_in,
    // strobes
    output wire        bit_end_out,
    output wire [2:0]  sample_out
);

    reg  [15:0] cnt_q;
    reg  [3:0]  acc_q;
    reg         ext_q;
    wire [3:0]  low_sum;
    wire [15:0] last;
    wire [15:0] half;

    ////////////////////////////////////////////////////////////////////////
    // carry out of the low three accumulator bits lengthens the bit
    assign low_sum     = {1'b0, acc_q[2:0]} + {1'b0, fraction_in};
    assign last        = divisor_in - 16'h0001 + {15'h0000, ext_q};
    assign bit_end_out = (cnt_q == last);
    assign half        = {1'b0, divisor_in[15:1]};

    // sample points from the bit start; range 1 moves the first two earlier
    assign sample_out[0] = range_sel_in ? (cnt_q == half - 16'h0001) : (cnt_q == half);
    assign sample_out[1] = range_sel_in ? (cnt_q == half) : (cnt_q == half + 16'h0001);
    assign sample_out[2] = (cnt_q == half + 16'h0002);

    ////////////////////////////////////////////////////////////////////////
    // free-running counter, restart loads the fraction into the accumulator so start bit adds first
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
            acc_q <= 4'h0;
            ext_q <= 1'b0;
        end else if (restart_in) begin
            cnt_q <= 16'h0000;
            acc_q <= {1'b0, fraction_in};
            ext_q <= 1'b0;
        end else if (bit_end_out) begin
            cnt_q <= 16'h0000;
            acc_q <= acc_q + {1'b0, fraction_in};
            ext_q <= low_sum[3];
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule // bit_timer

`default_nettype wire

/* rtl/rx_bit_vote.v */
// three-sample majority vote for one received bit
// assumes the line input is already synchronous to the clock
`timescale 1ns/1ps
`default_nettype none

module rx_bit_vote (
    // clock and reset
    input  wire       clk_in,
    input  wire       rst_n_in,
    // line and strobes
    input  wire       line_in,
    input  wire [2:0] sample_in,
    // decision
    output wire       bit_out
);

    reg [2:0] smp_q;

    ////////////////////////////////////////////////////////////////////////
    // one flop per sample point
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_smp
            always @(posedge clk_in) begin
                if (!rst_n_in) begin
                    smp_q[i] <= 1'b1;
                end else if (sample_in[i]) begin
                    smp_q[i] <= line_in;
                end
            end
        end
    endgenerate

    // majority tolerates one glitched sample
    assign bit_out = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);

endmodule // rx_bit_vote

`default_nettype wire

/* rtl/uart_baud_gen_rx_fifo.v */
// uart channel: baud generator, simple 8n1 shifters, 4-byte receive fifo
// assumes an avalon-mm master and a serial input synchronous to clk_in
//
// What this block does
// - bit time is divisor plus fraction over eight uart clocks
// - a free-running 16-bit timer times each bit from the divisor
// - modulation added each bit; carry out of bit 2 adds one clock
// - sample points depend on range select around half the divisor
// - trigger level 00 needs 4 bytes, else 1, 2 or 3 or more
// - receive-available with receiver irq enable raises the interrupt
// - receive fifo is empty after reset
// - unread count rises per byte in, falls per byte read
// - fifth byte waits in holding register, sixth replaces it, count stays 4
// - unread count cleared on reset and around channel enable
// - unread count reads as a 3-bit read-only value
// - unused upper bits of fifo control and count read zero
// - lsb first, transmitter and receiver share rate and format
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`include "uart_brg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module uart_baud_gen_rx_fifo (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // avalon-mm slave
    input  wire [7:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    // serial line
    input  wire        rx_line_in,
    output reg         tx_line_out,
    // interrupt
    output reg         irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [7:0]  div_lo_q;
    reg  [15:0] div_q;
    reg  [5:0]  fcr_q;
    reg  [1:0]  ccr_q;
    reg  [3:0]  irq_stat_q;
    reg  [3:0]  irq_mask_q;
    reg  [31:0] rd_mux;

    wire [2:0]  fraction   = fcr_q[`FCR_FRAC_LSB +: 3];
    wire        range_sel  = fcr_q[`FCR_RANGE_BIT];
    wire [1:0]  trig_level = fcr_q[`FCR_TRIG_LSB +: 2];
    wire        chan_en    = ccr_q[`CCR_ENABLE_BIT];
    wire        rx_ie      = ccr_q[`CCR_RXIE_BIT];

    // bus handshake: take at edge 0, complete at edge 1
    wire        req      = avs_read_in | avs_write_in;
    wire        done     = req & ~avs_waitrequest_out;
    wire        wr_done  = done & avs_write_in;
    wire        rd_done  = done & avs_read_in;
    wire [7:0]  wbyte    = avs_writedata_in[7:0];

    ////////////////////////////////////////////////////////////////////////
    // receive fifo storage
    reg  [7:0]  fifo_q [0:3];
    reg  [1:0]  wr_ptr_q;
    reg  [1:0]  rd_ptr_q;
    reg  [2:0]  count_q;
    reg  [7:0]  hold_q;
    reg         hold_v_q;
    reg         avail_q;
    reg         avail_d;

    // receiver state
    localparam RX_IDLE  = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA  = 2'h2;
    localparam RX_STOP  = 2'h3;
    reg  [1:0]  rx_state_q;
    reg  [3:0]  rx_bits_q;
    reg  [7:0]  rx_shift_q;
    reg         rx_prev_q;
    reg         byte_in;
    reg         frame_err;
    reg         rx_restart;

    // transmitter state
    reg         tx_busy_q;
    reg  [9:0]  tx_shift_q;
    reg  [3:0]  tx_bits_q;
    reg         tx_done_ev;

    wire        rx_bit_end;
    wire [2:0]  rx_sample;
    wire        rx_bit;
    wire        tx_bit_end;
    wire        tx_start = wr_done & (avs_address_in == `OFS_DATA) & ~tx_busy_q & chan_en;

    ////////////////////////////////////////////////////////////////////////
    // timers and voter; tx and rx use the same divisor and fraction
    bit_timer u_rx_timer (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .restart_in   (rx_restart),
        .divisor_in   (div_q),
        .fraction_in  (fraction),
        .range_sel_in (range_sel),
        .bit_end_out  (rx_bit_end),
        .sample_out   (rx_sample)
    );

    bit_timer u_tx_timer (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .restart_in   (tx_start),
        .divisor_in   (div_q),
        .fraction_in  (fraction),
        .range_sel_in (range_sel),
        .bit_end_out  (tx_bit_end),
        .sample_out   ()
    );

    rx_bit_vote u_vote (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .line_in   (rx_line_in),
        .sample_in (rx_sample),
        .bit_out   (rx_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // receive frame control, combinational events
    always @* begin
        rx_restart = 1'b0;
        byte_in    = 1'b0;
        frame_err  = 1'b0;
        if (chan_en && rx_state_q == RX_IDLE && rx_prev_q && !rx_line_in) begin
            rx_restart = 1'b1;
        end
        if (chan_en && rx_state_q == RX_STOP && rx_bit_end) begin
            byte_in   = 1'b1;
            frame_err = ~rx_bit;
        end
    end

    // receiver sequencing; data shifted in lsb first
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_state_q <= RX_IDLE;
            rx_bits_q  <= 4'h0;
            rx_shift_q <= 8'h00;
            rx_prev_q  <= 1'b1;
        end else begin
            rx_prev_q <= rx_line_in;
            if (!chan_en) begin
                rx_state_q <= RX_IDLE;
            end else begin
                case (rx_state_q)
                    RX_IDLE: begin
                        if (rx_restart) begin
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_bit_end) begin
                            rx_bits_q  <= 4'h0;
                            rx_state_q <= rx_bit ? RX_IDLE : RX_DATA;  // false start drops out
                        end
                    end
                    RX_DATA: begin
                        if (rx_bit_end) begin
                            rx_shift_q <= {rx_bit, rx_shift_q[7:1]};
                            rx_bits_q  <= rx_bits_q + 4'h1;
                            if (rx_bits_q == `DATA_BITS - 4'h1) begin
                                rx_state_q <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_bit_end) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo push/pop; a full fifo parks the next byte in the holding register
    wire       pop       = rd_done & (avs_address_in == `OFS_DATA) & (count_q != 3'h0);
    wire       full      = (count_q == `FIFO_DEPTH);
    wire       push_hold = pop & hold_v_q;
    wire       push_new  = byte_in & ~hold_v_q & (~full | pop);
    wire       push      = push_hold | push_new;
    wire [7:0] push_data = push_hold ? hold_q : rx_shift_q;
    wire       park      = byte_in & ~push_new;
    wire       overrun   = park & hold_v_q & ~push_hold;  // sixth byte lost the fifth

    always @(posedge clk_in) begin
        if (!rst_n_in || !chan_en) begin
            wr_ptr_q <= 2'h0;
            rd_ptr_q <= 2'h0;
            count_q  <= 3'h0;
            hold_v_q <= 1'b0;
            hold_q   <= 8'h00;
        end else begin
            if (push) begin
                fifo_q[wr_ptr_q] <= push_data;
                wr_ptr_q         <= wr_ptr_q + 2'h1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 2'h1;
            end
            // net change; stays at 4 while the parked byte moves in
            count_q <= count_q + {2'h0, push} - {2'h0, pop};
            if (park) begin
                hold_q   <= rx_shift_q;
                hold_v_q <= 1'b1;
            end else if (push_hold) begin
                hold_v_q <= 1'b0;
            end
        end
    end

    // trigger level compare; code 00 means a full fifo
    always @* begin
        case (trig_level)
            2'h0:    avail_d = (count_q == `FIFO_DEPTH);
            2'h1:    avail_d = (count_q >= 3'h1);
            2'h2:    avail_d = (count_q >= 3'h2);
            2'h3:    avail_d = (count_q >= 3'h3);
            default: avail_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter: 8n1 frame, start bit first, data lsb first
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_busy_q   <= 1'b0;
            tx_shift_q  <= 10'h3FF;
            tx_bits_q   <= 4'h0;
            tx_line_out <= 1'b1;
            tx_done_ev  <= 1'b0;
        end else begin
            tx_done_ev <= 1'b0;
            if (!chan_en) begin
                tx_busy_q   <= 1'b0;
                tx_line_out <= 1'b1;
            end else if (tx_start) begin
                tx_busy_q   <= 1'b1;
                tx_shift_q  <= {1'b1, wbyte, 1'b0};
                tx_bits_q   <= 4'h0;
                tx_line_out <= 1'b0;
            end else if (tx_busy_q && tx_bit_end) begin
                tx_shift_q  <= {1'b1, tx_shift_q[9:1]};
                tx_line_out <= tx_shift_q[1];
                tx_bits_q   <= tx_bits_q + 4'h1;
                if (tx_bits_q == `TX_FRAME_BITS - 4'h1) begin
                    tx_busy_q   <= 1'b0;
                    tx_line_out <= 1'b1;
                    tx_done_ev  <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes; divisor low is staged until the high byte commits
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_lo_q   <= `RST_DIV_LO;
            div_q      <= `RST_DIV;
            fcr_q      <= `RST_FCR;
            ccr_q      <= `RST_CCR;
            irq_mask_q <= `RST_MASK;
        end else if (wr_done) begin
            case (avs_address_in)
                `OFS_DIV_LO:    div_lo_q   <= wbyte;
                `OFS_DIV_HI:    div_q      <= {wbyte, div_lo_q};
                `OFS_FIFO_CTRL: fcr_q      <= wbyte[5:0];
                `OFS_CHAN_CTRL: ccr_q      <= wbyte[1:0];
                `OFS_IRQ_MASK:  irq_mask_q <= wbyte[3:0];
                default:        ccr_q      <= ccr_q;  // count and status ignore writes
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status; a new event in the clearing cycle survives the read
    wire [3:0] irq_set = {tx_done_ev, frame_err, overrun, avail_d & ~avail_q};
    wire       stat_rd = rd_done & (avs_address_in == `OFS_IRQ_STATUS);

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= 4'h0;
            avail_q    <= 1'b0;
            irq_out    <= 1'b0;
        end else begin
            avail_q    <= avail_d;
            irq_stat_q <= (stat_rd ? 4'h0 : irq_stat_q) | irq_set;
            irq_out    <= (avail_d & rx_ie) | (|(irq_stat_q & irq_mask_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; upper bits and unmapped addresses read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            `OFS_DIV_LO:      rd_mux[7:0] = div_lo_q;
            `OFS_DIV_HI:      rd_mux[7:0] = div_q[15:8];
            `OFS_FIFO_CTRL:   rd_mux[5:0] = fcr_q;
            `OFS_RX_COUNT:    rd_mux[2:0] = count_q;
            `OFS_DATA:        rd_mux[7:0] = (count_q != 3'h0) ? fifo_q[rd_ptr_q] : 8'h00;
            `OFS_CHAN_CTRL:   rd_mux[1:0] = ccr_q;
            `OFS_IRQ_STATUS:  rd_mux[3:0] = irq_stat_q;
            `OFS_IRQ_MASK:    rd_mux[3:0] = irq_mask_q;
            `OFS_LINE_STATUS: rd_mux[2:0] = {hold_v_q, tx_busy_q, avail_d};
            default:          rd_mux      = 32'h0000_0000;
        endcase
    end

    // one wait cycle per access; read data latched when the request is taken
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else if (req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= avs_read_in ? rd_mux : 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

endmodule // uart_baud_gen_rx_fifo

`default_nettype wire

/* rtl/uart_brg_defs.vh */
// constants for the baud generator and receive fifo channel
// assumes byte addresses on a 32-bit avalon bus, one word per register
`ifndef UART_BRG_DEFS_VH
`define UART_BRG_DEFS_VH

// register byte offsets
`define OFS_DIV_LO      8'h00
`define OFS_DIV_HI      8'h04
`define OFS_FIFO_CTRL   8'h08
`define OFS_RX_COUNT    8'h0C
`define OFS_DATA        8'h10
`define OFS_CHAN_CTRL   8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_IRQ_MASK    8'h1C
`define OFS_LINE_STATUS 8'h20

// fifo_control_reg fields
`define FCR_TRIG_LSB    0
`define FCR_RANGE_BIT   2
`define FCR_FRAC_LSB    3

// channel control fields
`define CCR_ENABLE_BIT  0
`define CCR_RXIE_BIT    1

// reset values
`define RST_DIV         16'h0000
`define RST_DIV_LO      8'h00
`define RST_FCR         6'h00
`define RST_CCR         2'h0
`define RST_MASK        4'h0

// fifo geometry and frame shape
`define FIFO_DEPTH      3'h4
`define DATA_BITS       4'h8
`define TX_FRAME_BITS   4'hA

`endif
